// ===== core/monitor_alert_pkg.sv
package monitor_alert_pkg;

    // ----------------------------------------------------------------
    // register map
    // ----------------------------------------------------------------
    localparam logic [7:0] ADDR_MASK = 8'h1f;
    localparam logic [7:0] ADDR_QUEUE = 8'h22;
    localparam logic [7:0] ADDR_GAIN = 8'h25;
    localparam logic [7:0] ADDR_FACTOR = 8'h27;
    localparam logic [7:0] ADDR_UPPER = 8'h35;

    localparam logic [7:0] MASK_RST = 8'h00;
    localparam logic [7:0] QUEUE_RST = 8'h70;
    localparam logic [7:0] GAIN_RST = 8'h10;
    localparam logic [7:0] FACTOR_RST = 8'h12;
    localparam logic [7:0] FACTOR_BASE = 8'h10;
    localparam logic [7:0] UPPER_RST = 8'h00;

    // writable mask and queue bits, valid status bits; reserved bits stay zero
    localparam logic [7:0] MASK_WMASK = 8'he3;
    localparam logic [7:0] QUEUE_WMASK = 8'hfe;
    localparam logic [7:0] UPPER_VALID = 8'hc3;

    // ----------------------------------------------------------------
    // field positions
    // ----------------------------------------------------------------
    localparam int BIT_SHUNT = 7;
    localparam int BIT_SUPPLY = 6;
    localparam int BIT_PEAK = 5;
    localparam int BIT_REMOTE = 1;
    localparam int BIT_LOCAL = 0;
    localparam int TIMEOUT_EN_BIT = 7;
    localparam int CRIT_CNT_LSB = 4;
    localparam int INT_CNT_LSB = 1;
    localparam int GAIN_AUTO_BIT = 4;

    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int CLK_HZ = 50_000_000;
    localparam int BUS_TIMEOUT_MS = 30;
    localparam int BUS_TIMEOUT_CYCLES = BUS_TIMEOUT_MS * (CLK_HZ / 1000);

    localparam logic [2:0] CNT_MAX = 3'h4;

    typedef struct packed {
        logic high;
        logic low;
        logic fault;
        logic crit;
    } chan_evt_t;

    typedef enum logic [2:0] {
        TO_IDLE = 3'h1,
        TO_COUNT = 3'h2,
        TO_FIRED = 3'h4
    } timeout_state_t;

    // thermometer code 000/001/011/111 gives 1..4 measurements
    function automatic logic [2:0] count_threshold(input logic [2:0] code);
        count_threshold = {2'h0, code[0]} + {2'h0, code[1]} + {2'h0, code[2]} + 3'h1;
    endfunction : count_threshold

    // saturating consecutive counter; a clean measurement restarts it
    function automatic logic [2:0] next_count(input logic [2:0] cnt, input logic hit);
        if (!hit)
            next_count = 3'h0;
        else if (cnt == CNT_MAX)
            next_count = cnt;
        else
            next_count = cnt + 3'h1;
    endfunction : next_count

endpackage : monitor_alert_pkg

// ===== core/monitor_alert_qualification.sv
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - masked channel never drives interrupt pin; masks never touch critical pin
// - mask bit 7 blocks shunt, bit 6 blocks supply violations
// - mask bit 5 blocks current spikes from interrupt pin only
// - mask bit 1 blocks remote diode limits and faults
// - mask bit 0 blocks local diode limit results
// - bits 3..1 set consecutive count for temperature interrupt counters
// - bits 6..4 set consecutive crit count, reset value four
// - these counts govern temperature only; voltages use own queue codes
// - comparator mode counts only high-limit and crit hits, ignores low and faults
// - remote diode keeps separate high, low and fault queues
// - bit 7 enables 30 ms bus clock low timeout reset
// - auto-detect applies detected gain at each conversion start
// - without auto-detect the programmed gain setting is used
// - gain field reads setting in use; writes ignored under auto
// - factor register holds three-bit code, reads 10h..17h, resets 12h
// - high status bit set on limit reached; summary follows
// - bit 7 shunt, 6 supply, 1 remote, 0 local
// - reading high status clears only conditions no longer present
// - interrupt needs an unmasked source: status set, low or fault count reached, or a spike in comparator mode
// - status sticky until read, live in comparator mode
// - comparator mode selected by configuration bit 5
// - summary high flag covers masked status bits too and does not drive the interrupt pin
module monitor_alert_qualification
    import monitor_alert_pkg::*;
#(
    parameter int TIMEOUT_CYCLES = BUS_TIMEOUT_CYCLES
) (
    input wire logic mclk,
    input wire logic reset,
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic regWrEn,
    input wire logic regRdEn,
    output logic [7:0] regRdData,
    input wire logic compMode,
    input wire logic maskAll,
    input wire logic tempDone,
    input wire logic convStart,
    input wire logic [3:0] detectedGain,
    input wire chan_evt_t localEvt,
    input wire chan_evt_t remoteEvt,
    input wire logic shuntDone,
    input wire chan_evt_t shuntEvt,
    input wire logic [1:0] shuntQueue,
    input wire logic supplyDone,
    input wire chan_evt_t supplyEvt,
    input wire logic [1:0] supplyQueue,
    input wire logic peakDetect,
    input wire logic peakToCritical,
    input wire logic serialBusClock,
    output logic interruptOutO,
    output logic interruptOutOe_n,
    output logic criticalOutO,
    output logic criticalOutOe_n,
    output logic highSummary,
    output logic [3:0] gainSetting,
    output logic [2:0] diodeFactorCode,
    output logic busTimeoutReset
);

    localparam int TW = $clog2(TIMEOUT_CYCLES + 1);
    localparam logic [TW-1:0] TO_LIMIT = TW'(TIMEOUT_CYCLES);

    typedef struct packed {
        logic [7:0] mask;
        logic [7:0] queue;
        logic gainAuto;
        logic [3:0] gain;
        logic [2:0] factor;
        logic [7:0] upper;
        logic summary;
        logic [2:0] locCnt;
        logic [2:0] remHiCnt;
        logic [2:0] remLoCnt;
        logic [2:0] remFltCnt;
        logic [2:0] shHiCnt;
        logic [2:0] shLoCnt;
        logic [2:0] suHiCnt;
        logic [2:0] suLoCnt;
        logic [2:0] locCritCnt;
        logic [2:0] remCritCnt;
        logic sclkMeta;
        logic sclkSync;
        timeout_state_t toState;
        logic [TW-1:0] toCnt;
        logic busRst;
        logic [7:0] rdData;
        logic intOe_n;
        logic critOe_n;
    } state_t;

    state_t st_q;
    state_t st_d;

    logic [2:0] thrInt;
    logic [2:0] thrCrit;
    logic [2:0] thrShunt;
    logic [2:0] thrSupply;
    logic [7:0] qualHi;
    logic [7:0] srcIntr;
    logic alertAct;
    logic critAct;
    logic readUpper;

    // ----------------------------------------------------------------
    // qualification and pin decisions
    // ----------------------------------------------------------------
    always_comb
    begin
        thrInt = count_threshold(st_q.queue[INT_CNT_LSB +: 3]);
        thrCrit = count_threshold(st_q.queue[CRIT_CNT_LSB +: 3]);
        thrShunt = {1'b0, shuntQueue} + 3'h1;
        thrSupply = {1'b0, supplyQueue} + 3'h1;
        qualHi = 8'h00;
        qualHi[BIT_SHUNT] = shuntEvt.high && st_q.shHiCnt >= thrShunt;
        qualHi[BIT_SUPPLY] = supplyEvt.high && st_q.suHiCnt >= thrSupply;
        qualHi[BIT_REMOTE] = remoteEvt.high && st_q.remHiCnt >= thrInt;
        qualHi[BIT_LOCAL] = localEvt.high && st_q.locCnt >= thrInt;
        srcIntr = 8'h00;
        srcIntr[BIT_SHUNT] = st_q.upper[BIT_SHUNT] || st_q.shLoCnt >= thrShunt;
        srcIntr[BIT_SUPPLY] = st_q.upper[BIT_SUPPLY] || st_q.suLoCnt >= thrSupply;
        srcIntr[BIT_REMOTE] = st_q.upper[BIT_REMOTE] || st_q.remLoCnt >= thrInt
            || st_q.remFltCnt >= thrInt;
        srcIntr[BIT_LOCAL] = st_q.upper[BIT_LOCAL] || st_q.locCnt >= thrInt;
        // spikes reach the interrupt pin only in comparator mode
        if (compMode)
            alertAct = |(st_q.upper & ~st_q.mask & UPPER_VALID)
                || (peakDetect && !peakToCritical && !st_q.mask[BIT_PEAK]);
        else
            alertAct = !maskAll && |(srcIntr & ~st_q.mask);
        // no mask term here at all
        critAct = st_q.locCritCnt >= thrCrit || st_q.remCritCnt >= thrCrit
            || shuntEvt.crit || supplyEvt.crit || (peakDetect && peakToCritical);
        readUpper = regRdEn && regAddr == ADDR_UPPER;
    end

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb
    begin
        st_d = st_q;
        st_d.intOe_n = !alertAct;
        st_d.critOe_n = !critAct;

        // comparator mode leaves only the high and crit queues counting
        if (tempDone)
        begin
            st_d.locCnt = next_count(st_q.locCnt, localEvt.high || (!compMode && localEvt.low));
            st_d.remHiCnt = next_count(st_q.remHiCnt, remoteEvt.high);
            st_d.remLoCnt = next_count(st_q.remLoCnt, !compMode && remoteEvt.low);
            st_d.remFltCnt = next_count(st_q.remFltCnt, !compMode && remoteEvt.fault);
            st_d.locCritCnt = next_count(st_q.locCritCnt, localEvt.crit);
            st_d.remCritCnt = next_count(st_q.remCritCnt, remoteEvt.crit);
        end
        if (shuntDone)
        begin
            st_d.shHiCnt = next_count(st_q.shHiCnt, shuntEvt.high);
            st_d.shLoCnt = next_count(st_q.shLoCnt, !compMode && shuntEvt.low);
        end
        if (supplyDone)
        begin
            st_d.suHiCnt = next_count(st_q.suHiCnt, supplyEvt.high);
            st_d.suLoCnt = next_count(st_q.suLoCnt, !compMode && supplyEvt.low);
        end

        // a new hit in the read cycle outlives the clear
        if (compMode)
            st_d.upper = qualHi;
        else if (readUpper)
            st_d.upper = (st_q.upper & qualHi) | qualHi;
        else
            st_d.upper = st_q.upper | qualHi;
        st_d.summary = |st_d.upper;

        if (regWrEn)
        begin
            case (regAddr)
                ADDR_MASK: st_d.mask = regWrData & MASK_WMASK;
                ADDR_QUEUE: st_d.queue = regWrData & QUEUE_WMASK;
                ADDR_GAIN:
                begin
                    st_d.gainAuto = regWrData[GAIN_AUTO_BIT];
                    if (!st_q.gainAuto)
                        st_d.gain = regWrData[3:0];
                end
                ADDR_FACTOR: st_d.factor = regWrData[2:0];
                default: ;
            endcase
        end
        if (convStart && st_q.gainAuto)
            st_d.gain = detectedGain;

        if (regRdEn)
        begin
            case (regAddr)
                ADDR_MASK: st_d.rdData = st_q.mask;
                ADDR_QUEUE: st_d.rdData = st_q.queue;
                ADDR_GAIN: st_d.rdData = {3'h0, st_q.gainAuto, st_q.gain};
                ADDR_FACTOR: st_d.rdData = FACTOR_BASE | {5'h00, st_q.factor};
                ADDR_UPPER: st_d.rdData = st_q.upper;
                default: st_d.rdData = 8'h00;
            endcase
        end

        // bus clock low timeout; the first sync stage feeds only the second
        st_d.sclkMeta = serialBusClock;
        st_d.sclkSync = st_q.sclkMeta;
        st_d.busRst = 1'b0;
        case (st_q.toState)
            TO_IDLE:
            begin
                st_d.toCnt = '0;
                if (st_q.queue[TIMEOUT_EN_BIT] && !st_q.sclkSync)
                    st_d.toState = TO_COUNT;
            end
            TO_COUNT:
            begin
                if (!st_q.queue[TIMEOUT_EN_BIT] || st_q.sclkSync)
                    st_d.toState = TO_IDLE;
                else if (st_q.toCnt == TO_LIMIT)
                begin
                    st_d.toState = TO_FIRED;
                    st_d.busRst = 1'b1;
                end
                else
                    st_d.toCnt = st_q.toCnt + TW'(1);
            end
            TO_FIRED:
            begin
                if (!st_q.queue[TIMEOUT_EN_BIT] || st_q.sclkSync)
                    st_d.toState = TO_IDLE;
            end
            default: st_d.toState = TO_IDLE;
        endcase
    end

    // sync stages start at the bus clock's idle high level, so no false low follows reset
    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
            st_q <= '{mask: MASK_RST, queue: QUEUE_RST, gainAuto: GAIN_RST[GAIN_AUTO_BIT],
                      gain: GAIN_RST[3:0], factor: FACTOR_RST[2:0], upper: UPPER_RST, sclkMeta: 1'b1, sclkSync: 1'b1,
                      toState: TO_IDLE, intOe_n: 1'b1, critOe_n: 1'b1, default: '0};
        else
            st_q <= st_d;
    end

    assign regRdData = st_q.rdData;
    assign interruptOutO = 1'b0;
    assign interruptOutOe_n = st_q.intOe_n;
    assign criticalOutO = 1'b0;
    assign criticalOutOe_n = st_q.critOe_n;
    assign highSummary = st_q.summary;
    assign gainSetting = st_q.gain;
    assign diodeFactorCode = st_q.factor;
    assign busTimeoutReset = st_q.busRst;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (reset);

    sequence s_read_upper;
        regRdEn && regAddr == ADDR_UPPER;
    endsequence

    sequence s_gain_write_locked;
        regWrEn && regAddr == ADDR_GAIN && st_q.gainAuto && !convStart;
    endsequence

    property p_spike_to_critical;
        peakDetect && peakToCritical |=> !criticalOutOe_n;
    endproperty
    a_spike_to_critical: assert property (p_spike_to_critical) else $error("spike did not drive critical pin");
    property p_masked_quiet;
        !compMode && (srcIntr & ~st_q.mask) == 8'h00 |=> interruptOutOe_n;
    endproperty
    a_masked_quiet: assert property (p_masked_quiet) else $error("interrupt pin driven without source");
    property p_comp_all_masked;
        compMode && st_q.mask == MASK_WMASK |=> interruptOutOe_n;
    endproperty
    a_comp_all_masked: assert property (p_comp_all_masked) else $error("masked channel drove interrupt");
    property p_remote_count;
        !compMode && !st_q.upper[BIT_REMOTE] && st_q.remHiCnt < thrInt |=> !st_q.upper[BIT_REMOTE];
    endproperty
    a_remote_count: assert property (p_remote_count) else $error("remote high set before count met");
    property p_comp_ignore_low;
        compMode && tempDone |=> st_q.remLoCnt == 3'h0 && st_q.remFltCnt == 3'h0;
    endproperty
    a_comp_ignore_low: assert property (p_comp_ignore_low) else $error("low or fault counted in comparator");
    property p_timeout_pulse;
        busTimeoutReset |=> !busTimeoutReset ##1 st_q.toState != TO_COUNT || !st_q.sclkSync;
    endproperty
    a_timeout_pulse: assert property (p_timeout_pulse) else $error("timeout reset not a single pulse");
    property p_timeout_off;
        !st_q.queue[TIMEOUT_EN_BIT] |=> !busTimeoutReset;
    endproperty
    a_timeout_off: assert property (p_timeout_off) else $error("timeout fired while disabled");
    property p_auto_gain;
        convStart && st_q.gainAuto |=> gainSetting == $past(detectedGain);
    endproperty
    a_auto_gain: assert property (p_auto_gain) else $error("detected gain not applied");
    property p_gain_locked;
        s_gain_write_locked |=> gainSetting == $past(gainSetting);
    endproperty
    a_gain_locked: assert property (p_gain_locked) else $error("gain write took effect under auto");
    property p_factor_read;
        regRdEn && regAddr == ADDR_FACTOR |=> regRdData[7:3] == FACTOR_BASE[7:3];
    endproperty
    a_factor_read: assert property (p_factor_read) else $error("factor upper bits wrong");
    property p_read_keeps_live;
        s_read_upper ##0 (!compMode && qualHi[BIT_REMOTE]) |=> st_q.upper[BIT_REMOTE] ##1 highSummary;
    endproperty
    a_read_keeps_live: assert property (p_read_keeps_live) else $error("live condition cleared by read");
    property p_comp_follows;
        compMode |=> st_q.upper == $past(qualHi);
    endproperty
    a_comp_follows: assert property (p_comp_follows) else $error("status not live in comparator");
    property p_clean_resets;
        tempDone && !remoteEvt.high |=> st_q.remHiCnt == 3'h0;
    endproperty
    a_clean_resets: assert property (p_clean_resets) else $error("counter not cleared on clean");

endmodule : monitor_alert_qualification

`default_nettype wire

// ===== dv/bus_host_model.sv
`timescale 1ns/1ps
`default_nettype none

// --------------------------------------------------------
// host side: bus clock driver and open-drain pull-ups
// --------------------------------------------------------
module bus_host_model (
    input wire logic frameOn,
    input wire logic stretchLow,
    input wire logic interruptOutO,
    input wire logic interruptOutOe_n,
    input wire logic criticalOutO,
    input wire logic criticalOutOe_n,
    output logic serialBusClock,
    output logic alertPin,
    output logic critPin
);
    initial serialBusClock = 1'b1;

    // the clock idles high between frames; stretching holds it low as a stuck host would
    always #80 serialBusClock = stretchLow ? 1'b0 : (frameOn ? ~serialBusClock : 1'b1);

    // released pins float up through the pull-ups
    assign alertPin = interruptOutOe_n ? 1'b1 : interruptOutO;
    assign critPin = criticalOutOe_n ? 1'b1 : criticalOutO;
endmodule : bus_host_model

`default_nettype wire

// ===== dv/test_monitor_alert_qualification.sv
`timescale 1ns/1ps
`default_nettype none

module test_monitor_alert_qualification
    import monitor_alert_pkg::*;
;
    localparam chan_evt_t HI = 4'h8;
    localparam chan_evt_t CR = 4'h1;
    localparam chan_evt_t NONE = 4'h0;

    logic mclk = 1'b0;
    logic reset = 1'b1;
    logic [7:0] regAddr = 8'h00;
    logic [7:0] regWrData = 8'h00;
    logic regWrEn = 1'b0;
    logic regRdEn = 1'b0;
    logic [7:0] regRdData;
    logic compMode = 1'b0;
    logic maskAll = 1'b0;
    logic tempDone = 1'b0;
    logic convStart = 1'b0;
    logic [3:0] detectedGain = 4'h0;
    chan_evt_t localEvt = 4'h0;
    chan_evt_t remoteEvt = 4'h0;
    logic shuntDone = 1'b0;
    chan_evt_t shuntEvt = 4'h0;
    logic [1:0] shuntQueue = 2'h0;
    logic supplyDone = 1'b0;
    chan_evt_t supplyEvt = 4'h0;
    logic [1:0] supplyQueue = 2'h0;
    logic peakDetect = 1'b0;
    logic peakToCritical = 1'b0;
    logic frameOn = 1'b0;
    logic stretchLow = 1'b0;
    logic serialBusClock;
    logic interruptOutO;
    logic interruptOutOe_n;
    logic criticalOutO;
    logic criticalOutOe_n;
    logic highSummary;
    logic [3:0] gainSetting;
    logic [2:0] diodeFactorCode;
    logic busTimeoutReset;
    logic alertPin;
    logic critPin;
    int miscompares = 0;
    int cmp_count = 0;
    int cycles = 0;

    always #10 mclk = ~mclk;

    // short bus timeout keeps the stall scenario brief
    monitor_alert_qualification #(.TIMEOUT_CYCLES(20)) DUT (.mclk, .reset, .regAddr, .regWrData, .regWrEn,
        .regRdEn, .regRdData, .compMode, .maskAll, .tempDone, .convStart, .detectedGain, .localEvt, .remoteEvt,
        .shuntDone, .shuntEvt, .shuntQueue, .supplyDone, .supplyEvt, .supplyQueue, .peakDetect, .peakToCritical,
        .serialBusClock, .interruptOutO, .interruptOutOe_n, .criticalOutO, .criticalOutOe_n, .highSummary,
        .gainSetting, .diodeFactorCode, .busTimeoutReset);

    bus_host_model host (.frameOn, .stretchLow, .interruptOutO, .interruptOutOe_n, .criticalOutO,
        .criticalOutOe_n, .serialBusClock, .alertPin, .critPin);

    // --------------------------------------------------------
    // shared tasks
    // --------------------------------------------------------
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : conclude

    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge mclk);
        regAddr = a;
        regWrData = d;
        regWrEn = 1'b1;
        @(negedge mclk);
        regWrEn = 1'b0;
    endtask : wr

    task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
        @(negedge mclk);
        regAddr = a;
        regRdEn = 1'b1;
        @(negedge mclk);
        regRdEn = 1'b0;
        @(negedge mclk);
        check("regRdData", regRdData, exp);
    endtask : rchk

    // ch 0 local, 1 remote, 2 shunt, 3 supply; events stay held after the pulses
    task automatic hit(input int ch, input chan_evt_t e, input int n);
        repeat (n)
        begin
            @(negedge mclk);
            localEvt = (ch == 0) ? e : NONE;
            remoteEvt = (ch == 1) ? e : NONE;
            shuntEvt = (ch == 2) ? e : NONE;
            supplyEvt = (ch == 3) ? e : NONE;
            tempDone = (ch < 2);
            shuntDone = (ch == 2);
            supplyDone = (ch == 3);
            @(negedge mclk);
            tempDone = 1'b0;
            shuntDone = 1'b0;
            supplyDone = 1'b0;
        end
        repeat (4) @(negedge mclk);
    endtask : hit

    task automatic stall(input int n, input int exp);
        int p;
        p = 0;
        repeat (n)
        begin
            @(negedge mclk);
            if (busTimeoutReset === 1'b1)
                p++;
        end
        check("busTimeoutReset", 8'(p), 8'(exp));
    endtask : stall

    // --------------------------------------------------------
    // scenarios
    // --------------------------------------------------------
    task automatic s_reset_values();
        rchk(ADDR_MASK, 8'h00);
        rchk(ADDR_QUEUE, 8'h70);
        rchk(ADDR_GAIN, 8'h10);
        rchk(ADDR_FACTOR, 8'h12);
        rchk(ADDR_UPPER, 8'h00);
        rchk(8'h40, 8'h00);
    endtask : s_reset_values

    task automatic s_registers();
        wr(ADDR_MASK, 8'hff);
        rchk(ADDR_MASK, 8'he3);
        wr(ADDR_QUEUE, 8'hff);
        rchk(ADDR_QUEUE, 8'hfe);
        wr(ADDR_UPPER, 8'hff);
        rchk(ADDR_UPPER, 8'h00);
        wr(ADDR_MASK, 8'h00);
        wr(ADDR_QUEUE, 8'h70);
        wr(ADDR_FACTOR, 8'h17);
        rchk(ADDR_FACTOR, 8'h17);
        check("diodeFactorCode", {5'h0, diodeFactorCode}, 8'h07);
    endtask : s_registers

    task automatic s_gain();
        wr(ADDR_GAIN, 8'h0a);
        rchk(ADDR_GAIN, 8'h00);
        wr(ADDR_GAIN, 8'h0f);
        rchk(ADDR_GAIN, 8'h0f);
        check("gainSetting", {4'h0, gainSetting}, 8'h0f);
        wr(ADDR_GAIN, 8'h10);
        @(negedge mclk);
        detectedGain = 4'h9;
        convStart = 1'b1;
        @(negedge mclk);
        convStart = 1'b0;
        rchk(ADDR_GAIN, 8'h19);
        check("gainSetting", {4'h0, gainSetting}, 8'h09);
        wr(ADDR_GAIN, 8'h13);
        rchk(ADDR_GAIN, 8'h19);
    endtask : s_gain

    task automatic s_alert();
        hit(1, HI, 1);
        check("alertPin", alertPin, 1'b0);
        check("highSummary", highSummary, 1'b1);
        rchk(ADDR_UPPER, 8'h02);
        rchk(ADDR_UPPER, 8'h02);
        hit(1, NONE, 1);
        check("alertPin", alertPin, 1'b0);
        rchk(ADDR_UPPER, 8'h02);
        rchk(ADDR_UPPER, 8'h00);
        check("alertPin", alertPin, 1'b1);
        check("highSummary", highSummary, 1'b0);
        maskAll = 1'b1;
        hit(0, HI, 1);
        check("alertPin", alertPin, 1'b1);
        check("highSummary", highSummary, 1'b1);
        maskAll = 1'b0;
        hit(0, NONE, 1);
        check("alertPin", alertPin, 1'b0);
        rchk(ADDR_UPPER, 8'h01);
        rchk(ADDR_UPPER, 8'h00);
    endtask : s_alert

    task automatic s_masks();
        int pos[4] = '{0, 1, 7, 6};
        for (int i = 0; i < 4; i++)
        begin
            wr(ADDR_MASK, 8'h01 << pos[i]);
            hit(i, HI, 1);
            check("alertPin", alertPin, 1'b1);
            rchk(ADDR_UPPER, 8'h01 << pos[i]);
            hit(i, NONE, 1);
            rchk(ADDR_UPPER, 8'h01 << pos[i]);
            rchk(ADDR_UPPER, 8'h00);
        end
        wr(ADDR_MASK, 8'h00);
        hit(1, 4'h2, 1);
        check("alertPin", alertPin, 1'b0);
        rchk(ADDR_UPPER, 8'h00);
        wr(ADDR_MASK, 8'h02);
        hit(1, 4'h2, 1);
        check("alertPin", alertPin, 1'b1);
        wr(ADDR_MASK, 8'h02);
        hit(1, CR, 3);
        check("critPin", critPin, 1'b1);
        hit(1, CR, 1);
        check("critPin", critPin, 1'b0);
        hit(1, NONE, 1);
        check("critPin", critPin, 1'b1);
        wr(ADDR_MASK, 8'h00);
    endtask : s_masks

    task automatic s_consecutive();
        wr(ADDR_QUEUE, 8'h76);
        hit(2, HI, 1);
        check("highSummary", highSummary, 1'b1);
        hit(2, NONE, 1);
        rchk(ADDR_UPPER, 8'h80);
        rchk(ADDR_UPPER, 8'h00);
        hit(1, HI, 2);
        check("highSummary", highSummary, 1'b0);
        hit(1, NONE, 1);
        hit(1, HI, 2);
        check("highSummary", highSummary, 1'b0);
        hit(1, HI, 1);
        check("highSummary", highSummary, 1'b1);
        hit(1, NONE, 1);
        rchk(ADDR_UPPER, 8'h02);
        rchk(ADDR_UPPER, 8'h00);
        wr(ADDR_QUEUE, 8'h70);
    endtask : s_consecutive

    task automatic s_comparator();
        compMode = 1'b1;
        maskAll = 1'b1;
        hit(1, 4'h6, 1);
        check("alertPin", alertPin, 1'b1);
        hit(1, HI, 1);
        check("alertPin", alertPin, 1'b0);
        hit(1, NONE, 1);
        check("highSummary", highSummary, 1'b0);
        check("alertPin", alertPin, 1'b1);
        wr(ADDR_MASK, 8'h20);
        peakDetect = 1'b1;
        hit(0, NONE, 1);
        check("alertPin", alertPin, 1'b1);
        peakToCritical = 1'b1;
        hit(0, NONE, 1);
        check("critPin", critPin, 1'b0);
        peakToCritical = 1'b0;
        wr(ADDR_MASK, 8'h00);
        hit(0, NONE, 1);
        check("alertPin", alertPin, 1'b0);
        peakDetect = 1'b0;
        compMode = 1'b0;
        maskAll = 1'b0;
        hit(0, NONE, 1);
    endtask : s_comparator

    task automatic s_timeout();
        frameOn = 1'b1;
        stall(60, 0);
        stretchLow = 1'b1;
        stall(60, 0);
        stretchLow = 1'b0;
        wr(ADDR_QUEUE, 8'hf0);
        stall(60, 0);
        stretchLow = 1'b1;
        stall(60, 1);
        stretchLow = 1'b0;
        frameOn = 1'b0;
        stall(20, 0);
    endtask : s_timeout

    // --------------------------------------------------------
    // run
    // --------------------------------------------------------
    always @(posedge mclk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            miscompares++;
            conclude();
        end
    end

    initial
    begin
        repeat (8) @(negedge mclk);
        reset = 1'b0;
        s_reset_values();
        s_registers();
        s_gain();
        s_alert();
        s_masks();
        s_consecutive();
        s_comparator();
        s_timeout();
        conclude();
    end
endmodule : test_monitor_alert_qualification

`default_nettype wire
